// >>> rtl/ptp_tx_filter_map.vh
/*
 * register offsets, field positions and reset values of the transmit
 * ptp filter / modify block. assumes byte addressing on a 32-bit apb.
 */
`ifndef PTP_TX_FILTER_MAP_VH
`define PTP_TX_FILTER_MAP_VH

// ****************************************
// offsets
// ****************************************
`define OFS_PARSE_EN 12'h158
`define OFS_FILTER_CFG 12'h15c
`define OFS_MODIFY_CTL 12'h164
`define OFS_BANK_PORT_SEL 12'h000

// ****************************************
// fields
// ****************************************
`define F_IP_DEST_CHK 4
`define F_MAC_DEST_CHK 3
`define F_L2_DET 2
`define F_UDP6_DET 1
`define F_UDP4_DET 0
`define F_DOMAIN_HI 31
`define F_DOMAIN_LO 24
`define F_DOMAIN_EN 23
`define F_ALT_MASTER_EN 22
`define F_UDP_SUM_OFF 21
`define F_FCS_OFF 20
`define F_VERSION_HI 19
`define F_VERSION_LO 16
`define F_CLR_QUAD 31
`define F_SUPP_CF 30
`define F_TA_INSERT 29
`define F_SYNC_INSERT 28
`define F_QUAD_OFS_HI 27
`define F_QUAD_OFS_LO 22
`define F_SEC_OFS_HI 21
`define F_SEC_OFS_LO 16
`define F_BANK_HI 2
`define F_BANK_LO 0
`define F_PORT_HI 5
`define F_PORT_LO 4

// ****************************************
// reset values and bank
// ****************************************
`define RST_PARSE_EN 32'h0000001f
`define RST_FILTER_CFG 32'h00020000
`define RST_MODIFY_CTL 32'h0405000f
`define RST_QUAD_OFS 6'h10
`define RST_SEC_OFS 6'h05
`define PORT_BANK 3'h2
`define NUM_PORTS 3

`endif

// >>> rtl/ptp_tx_timestamp_filter_modify.v
/*
 * per-port transmit ptp classifier and modifier with banked apb registers.
 * assumes the egress parser supplies per-frame header fields and check
 * results on frame_done, all in the ref_clk domain.
 */
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "ptp_tx_filter_map.vh"

// What this block does
// - with ip check set, ipv4/ipv6 destination address must be enabled
// - with mac check set, destination mac must be in enabled set
// - layer 2 ptp detected only while l2 detect enable set
// - udp over ipv6 ptp detected only while ipv6 enable set
// - udp over ipv4 ptp detected only while ipv4 enable set
// - domain match enabled requires domainNumber equal to programmed domain
// - alternate master check requires alternateMasterFlag zero
// - bad udp checksum drops egress time unless check disabled
// - bad fcs drops egress time unless check disabled
// - version must equal field; zero accepts any version
// - timestamp only message types enabled in the stamp mask
// - clear four reserved bytes of modified frames when enabled
// - suppress egress time of frames with edited correction field
// - insert turnaround time into host pdelay_resp correction field
// - insert egress time into host sync originTimestamp
// - reserved quad located at programmed header offset
// - ingress seconds read from programmed header offset
// - correction field edited for types in edit mask and for turnaround inserts
// - bank and port select steer register accesses to port copies
module ptp_tx_timestamp_filter_modify (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire timestamp_enable,
    input wire [1:0] frame_port,
    input wire frame_done,
    input wire [1:0] frame_format,
    input wire mac_dest_ok,
    input wire ip_dest_ok,
    input wire [3:0] msg_type,
    input wire [3:0] msg_version,
    input wire [7:0] msg_domain,
    input wire alt_master_flag,
    input wire udp_sum_ok,
    input wire fcs_ok,
    input wire from_host,
    output reg save_egress_time,
    output reg is_ptp,
    output reg cf_edit,
    output reg turnaround_insert,
    output reg sync_origin_insert,
    output reg clear_quad_reserved,
    output reg [5:0] quad_reserved_offset,
    output reg [5:0] ingress_sec_offset,
    output reg [1:0] result_port,
    output reg config_write_while_on
);

// frame_format: 0 none, 1 layer 2, 2 udp/ipv4, 3 udp/ipv6
localparam [1:0] FMT_L2 = 2'h1;
localparam [1:0] FMT_UDP4 = 2'h2;
localparam [1:0] FMT_UDP6 = 2'h3;

// ****************************************
// registers
// ****************************************
reg [31:0] parse_en_q [0:`NUM_PORTS-1];
reg [31:0] filter_cfg_q [0:`NUM_PORTS-1];
reg [31:0] modify_ctl_q [0:`NUM_PORTS-1];
reg [2:0] bank_sel_q;
reg [1:0] port_sel_q;
integer i;

wire setup = psel && !penable;
wire access = psel && penable;
wire port_ok = ({1'b0, port_sel_q} < 3'h3) && (bank_sel_q == `PORT_BANK);
wire hit_parse = (paddr == `OFS_PARSE_EN);
wire hit_filt = (paddr == `OFS_FILTER_CFG);
wire hit_mod = (paddr == `OFS_MODIFY_CTL);
wire hit_sel = (paddr == `OFS_BANK_PORT_SEL);
wire hit_cfg = (hit_parse || hit_filt || hit_mod) && port_ok;

// ****************************************
// apb answer
// ****************************************
// read word picked in the setup cycle, so it stands in the access cycle
reg [31:0] rd_word;

always @* begin
    rd_word = 32'h0;
    if (hit_sel) begin
        rd_word = {26'h0, port_sel_q, 1'b0, bank_sel_q};
    end else if (hit_parse && port_ok) begin
        rd_word = {27'h0, parse_en_q[port_sel_q][4:0]};
    end else if (hit_filt && port_ok) begin
        rd_word = filter_cfg_q[port_sel_q];
    end else if (hit_mod && port_ok) begin
        rd_word = modify_ctl_q[port_sel_q];
    end else begin
        rd_word = 32'h0;
    end
end

// one wait-free answer: ready in the access phase
always @(posedge ref_clk) begin
    if (rst) begin
        pready <= 1'b0;
    end else begin
        pready <= setup;
    end
end

// unmapped address or bad bank/port: error, write dropped, read zero
always @(posedge ref_clk) begin
    if (rst) begin
        pslverr <= 1'b0;
    end else begin
        pslverr <= setup && !(hit_cfg || hit_sel);
    end
end

// read data stands only in the access cycle
always @(posedge ref_clk) begin
    if (rst) begin
        prdata <= 32'h0;
    end else if (setup) begin
        prdata <= rd_word;
    end else begin
        prdata <= 32'h0;
    end
end

// writes land at the access edge where pready is seen high
wire wr = access && pready && pwrite;
// the select word itself needs no valid bank
wire wr_sel = wr && hit_sel;
wire wr_parse = wr && hit_parse && port_ok;
wire wr_filt = wr && hit_filt && port_ok;
wire wr_mod = wr && hit_mod && port_ok;
integer j;
integer k;

// ****************************************
// bank and port select
// ****************************************
always @(posedge ref_clk) begin
    if (rst) begin
        bank_sel_q <= 3'h0;
        port_sel_q <= 2'h0;
    end else if (wr_sel) begin
        bank_sel_q <= pwdata[`F_BANK_HI:`F_BANK_LO];
        port_sel_q <= pwdata[`F_PORT_HI:`F_PORT_LO];
    end
end

// writes are still honoured; the flag only reports misuse
always @(posedge ref_clk) begin
    if (rst) begin
        config_write_while_on <= 1'b0;
    end else begin
        config_write_while_on <= wr && hit_cfg && timestamp_enable;
    end
end

// ****************************************
// per-port configuration copies
// ****************************************
// only bits 4:0 of the parse word exist; the rest read as zero
always @(posedge ref_clk) begin
    if (rst) begin
        for (i = 0; i < `NUM_PORTS; i = i + 1) begin
            parse_en_q[i] <= `RST_PARSE_EN;
        end
    end else if (wr_parse) begin
        parse_en_q[port_sel_q] <= {27'h0, pwdata[4:0]};
    end
end

// domain, flags, version and stamp mask
always @(posedge ref_clk) begin
    if (rst) begin
        for (j = 0; j < `NUM_PORTS; j = j + 1) begin
            filter_cfg_q[j] <= `RST_FILTER_CFG;
        end
    end else if (wr_filt) begin
        filter_cfg_q[port_sel_q] <= pwdata;
    end
end

// edit enables, offsets and correction mask
always @(posedge ref_clk) begin
    if (rst) begin
        for (k = 0; k < `NUM_PORTS; k = k + 1) begin
            modify_ctl_q[k] <= `RST_MODIFY_CTL;
        end
    end else if (wr_mod) begin
        modify_ctl_q[port_sel_q] <= pwdata;
    end
end

// ****************************************
// classification
// ****************************************
// frame_port 3 has no register copy; it falls back to port 0
wire [1:0] fp = (frame_port < 2'h3) ? frame_port : 2'h0;
wire [31:0] pe = parse_en_q[fp];
wire [31:0] fc = filter_cfg_q[fp];
wire [31:0] mc = modify_ctl_q[fp];

reg fmt_ok;
reg is_ip;

// format detection and the ip-only checks
always @* begin
    fmt_ok = 1'b0;
    is_ip = 1'b0;
    case (frame_format)
        FMT_L2: begin
            fmt_ok = pe[`F_L2_DET];
            is_ip = 1'b0;
        end
        FMT_UDP4: begin
            fmt_ok = pe[`F_UDP4_DET];
            is_ip = 1'b1;
        end
        FMT_UDP6: begin
            fmt_ok = pe[`F_UDP6_DET];
            is_ip = 1'b1;
        end
        default: begin
            // format 0 is not ptp at all
            fmt_ok = 1'b0;
            is_ip = 1'b0;
        end
    endcase
end
wire ip_ok = !is_ip || !pe[`F_IP_DEST_CHK] || ip_dest_ok;
wire mac_ok = !pe[`F_MAC_DEST_CHK] || mac_dest_ok;
wire ptp = fmt_ok && ip_ok && mac_ok;

reg dom_ok;
reg alt_ok;
reg sum_ok;
reg crc_ok;
reg ver_ok;
wire [3:0] ver_f = fc[`F_VERSION_HI:`F_VERSION_LO];

// per-message checks; each passes when its check is switched off
always @* begin
    dom_ok = 1'b1;
    alt_ok = 1'b1;
    sum_ok = 1'b1;
    crc_ok = 1'b1;
    ver_ok = 1'b1;
    if (fc[`F_DOMAIN_EN]) begin
        dom_ok = (msg_domain == fc[`F_DOMAIN_HI:`F_DOMAIN_LO]);
    end
    if (fc[`F_ALT_MASTER_EN]) begin
        alt_ok = !alt_master_flag;
    end
    // layer 2 frames carry no udp checksum
    if (is_ip && !fc[`F_UDP_SUM_OFF]) begin
        sum_ok = udp_sum_ok;
    end
    if (!fc[`F_FCS_OFF]) begin
        crc_ok = fcs_ok;
    end
    // a version field of zero accepts any version
    if (ver_f != 4'h0) begin
        ver_ok = (msg_version == ver_f);
    end
end

wire type_stamp = fc[msg_type];
wire type_edit = mc[msg_type];

// pdelay_resp is type 3, sync type 0
wire ta = ptp && from_host && mc[`F_TA_INSERT] && (msg_type == 4'h3);
wire sy = ptp && from_host && mc[`F_SYNC_INSERT] && (msg_type == 4'h0);
wire cfe = ptp && (type_edit || ta);
wire modified = cfe || sy;
wire supp = cfe && mc[`F_SUPP_CF];

// ****************************************
// per-frame result, one cycle after frame_done
// ****************************************
// the six flag results are one-cycle pulses, low when no frame ends
always @(posedge ref_clk) begin
    if (rst) begin
        save_egress_time <= 1'b0;
    end else begin
        save_egress_time <= frame_done && ptp && dom_ok && alt_ok && sum_ok
            && crc_ok && ver_ok && type_stamp && !supp;
    end
end

always @(posedge ref_clk) begin
    if (rst) begin
        is_ptp <= 1'b0;
    end else begin
        is_ptp <= frame_done && ptp;
    end
end

// correction edits include the turnaround insert
always @(posedge ref_clk) begin
    if (rst) begin
        cf_edit <= 1'b0;
    end else begin
        cf_edit <= frame_done && cfe;
    end
end

// host pdelay_resp only
always @(posedge ref_clk) begin
    if (rst) begin
        turnaround_insert <= 1'b0;
    end else begin
        turnaround_insert <= frame_done && ta;
    end
end

// host sync only
always @(posedge ref_clk) begin
    if (rst) begin
        sync_origin_insert <= 1'b0;
    end else begin
        sync_origin_insert <= frame_done && sy;
    end
end

// any modified frame, cf edit or sync insert
always @(posedge ref_clk) begin
    if (rst) begin
        clear_quad_reserved <= 1'b0;
    end else begin
        clear_quad_reserved <= frame_done && modified && mc[`F_CLR_QUAD];
    end
end

// offsets and port are levels: they hold until the next frame
always @(posedge ref_clk) begin
    if (rst) begin
        quad_reserved_offset <= `RST_QUAD_OFS;
    end else if (frame_done) begin
        quad_reserved_offset <= mc[`F_QUAD_OFS_HI:`F_QUAD_OFS_LO];
    end
end

always @(posedge ref_clk) begin
    if (rst) begin
        ingress_sec_offset <= `RST_SEC_OFS;
    end else if (frame_done) begin
        ingress_sec_offset <= mc[`F_SEC_OFS_HI:`F_SEC_OFS_LO];
    end
end

always @(posedge ref_clk) begin
    if (rst) begin
        result_port <= 2'h0;
    end else if (frame_done) begin
        result_port <= fp;
    end
end

endmodule

// >>> test/ptp_tx_chk.sv
/* assertions on the ports of the transmit ptp filter block.
   assumes it is bound to that block and sees only its ports. */
`timescale 1ns/1ps
module ptp_tx_chk (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire frame_done,
    input wire [1:0] frame_format,
    input wire [3:0] msg_type,
    input wire from_host,
    input wire save_egress_time,
    input wire is_ptp,
    input wire cf_edit,
    input wire turnaround_insert,
    input wire sync_origin_insert,
    input wire clear_quad_reserved
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_APB_ANSWER: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer wrong");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_SAVE_PTP: assert property (save_egress_time |-> is_ptp && $past(frame_done))
        else $error("save without ptp frame");
    AST_NO_FORMAT: assert property (frame_done && frame_format == 2'h0 |=> !is_ptp)
        else $error("unformatted frame taken");
    AST_IDLE: assert property (!frame_done |=> !(is_ptp || save_egress_time || cf_edit))
        else $error("pulse without frame");
    AST_TA: assert property (turnaround_insert |-> cf_edit && $past(from_host && msg_type == 4'h3))
        else $error("turnaround on wrong frame");
    AST_SYNC: assert property (sync_origin_insert |-> $past(from_host && msg_type == 4'h0))
        else $error("sync insert on wrong frame");
    AST_CLR: assert property (clear_quad_reserved |-> cf_edit || sync_origin_insert)
        else $error("clear on unmodified frame");
endmodule
bind ptp_tx_timestamp_filter_modify ptp_tx_chk chk_inst (.ref_clk, .rst, .psel, .penable,
    .pready, .pslverr, .frame_done, .frame_format, .msg_type, .from_host, .save_egress_time,
    .is_ptp, .cf_edit, .turnaround_insert, .sync_origin_insert, .clear_quad_reserved);

// >>> test/egress_src.sv
/* egress path model: hands one frame descriptor to the block per call.
   assumes calls start right after a rising edge. */
`timescale 1ns/1ps
module egress_src (
    input wire ref_clk,
    output logic frame_done,
    output logic [27:0] fld
);
    initial frame_done = 1'b0;
    initial fld = 28'h0;
    task send(input logic [27:0] v);
        fld <= v;
        frame_done <= 1'b1;
        @(posedge ref_clk);
        frame_done <= 1'b0;
        fld <= ~v; // stale fields must not look valid
        @(posedge ref_clk);
    endtask
endmodule

// >>> test/ptp_tx_timestamp_filter_modify_tb.sv
/* bench: random per-port configs and frames, expectations queued.
   assumes the egress model and the bound checker. */
`timescale 1ns/1ps
module ptp_tx_timestamp_filter_modify_tb;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ts_en = 0, fd_q = 0;
    logic pready, save, fd, perr, isp, cfo, tao, syo, clro, wr_q = 0;
    logic [5:0] qofs, sofs;
    logic [1:0] rport;
    logic [11:0] paddr = 12'h0;
    logic [27:0] f, v;
    logic [31:0] pwdata = 32'h0, prdata, pe, fc, md, r, seed = 32'h24;
    logic [31:0] exq[$];
    int err_total = 0, cmp_count = 0, cyc = 0;
    egress_src model_inst (.ref_clk(ref_clk), .frame_done(fd), .fld(f));
    ptp_tx_timestamp_filter_modify ptp_tx_timestamp_filter_modify_inst (.ref_clk(ref_clk),
        .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(perr),
        .timestamp_enable(ts_en),
        .frame_port(f[27:26]), .frame_done(fd), .frame_format(f[1:0]), .mac_dest_ok(f[2]),
        .ip_dest_ok(f[3]), .msg_type(f[7:4]), .msg_version(f[12:9]), .msg_domain(f[21:14]),
        .alt_master_flag(f[22]), .udp_sum_ok(f[23]), .fcs_ok(f[24]), .from_host(f[25]),
        .save_egress_time(save), .is_ptp(isp), .cf_edit(cfo), .turnaround_insert(tao),
        .sync_origin_insert(syo), .clear_quad_reserved(clro), .quad_reserved_offset(qofs),
        .ingress_sec_offset(sofs), .result_port(rport), .config_write_while_on(cww));
    logic cww;
    initial forever #5 ref_clk = ~ref_clk;
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function logic [31:0] exp_frame(input logic [27:0] a);
        logic ok, ptp, ta, sy, cfe, clr;
        ptp = a[1:0] == 2'h1 && pe[2] || a[1:0] == 2'h2 && pe[0] || a[1:0] == 2'h3 && pe[1];
        ptp = ptp && (a[2] || !pe[3]) && (a[3] || !a[1] || !pe[4]);
        ok = (a[21:14] == fc[31:24] || !fc[23]) && !(a[22] && fc[22]);
        ok = ok && (a[23] || !a[1] || fc[21]) && (a[24] || fc[20]);
        ok = ok && (fc[19:16] == 4'h0 || fc[19:16] == a[12:9]) && fc[a[7:4]];
        ta = ptp && a[25] && md[29] && a[7:4] == 4'h3;
        sy = ptp && a[25] && md[28] && a[7:4] == 4'h0;
        cfe = ptp && (md[a[7:4]] || ta);
        clr = md[31] && (cfe || sy);
        ok = ptp && ok && !(md[30] && cfe);
        return {12'h0, md[27:22], md[21:16], a[27:26], clr, sy, ta, cfe, ptp, ok};
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] e);
        cmp_count++;
        if (seen !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        if (w) exq.push_back({31'h0, ts_en && a != 12'h000});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
        exq.push_back(e);
        exq.push_back({31'h0, err});
        apb(1'b0, a, xs());
    endtask
    task finish_test();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 10000) begin
            err_total++;
            finish_test();
        end
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk(prdata, exq.pop_front());
            chk({31'h0, perr}, exq.pop_front());
        end
        if (wr_q) chk({31'h0, cww}, exq.pop_front());
        if (fd_q) chk({12'h0, qofs, sofs, rport, clro, syo, tao, cfo, isp, save}, exq.pop_front());
        fd_q <= fd;
        wr_q <= psel && penable && pready === 1'b1 && pwrite;
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b1, 12'h000, 32'h2);
        rd(12'h158, 32'h1f);
        rd(12'h15c, 32'h00020000);
        rd(12'h164, 32'h0405000f);
        rd(12'h100, 32'h0, 1'b1);
        apb(1'b1, 12'h000, 32'h32);
        rd(12'h15c, 32'h0, 1'b1);
        $display("reset and refusal test done");
        for (int i = 0; i < 64; i++) begin
            ts_en <= 1'b0;
            apb(1'b1, 12'h000, {26'h0, 2'(i % 3), 4'h2});
            pe = xs() | xs();
            fc = xs();
            md = xs();
            apb(1'b1, 12'h158, pe);
            apb(1'b1, 12'h15c, fc);
            apb(1'b1, 12'h164, md);
            rd(12'h15c, fc);
            ts_en <= 1'b1;
            repeat (8) begin
                r = xs();
                r[3:2] |= r[27:26];
                r[24:23] |= r[29:28];
                if (r[13]) r[21:14] = fc[31:24];
                if (r[8]) r[12:9] = fc[19:16];
                v = {2'(i % 3), r[25:0]};
                exq.push_back(exp_frame(v));
                model_inst.send(v);
            end
        end
        $display("random frame test done");
        apb(1'b1, 12'h15c, fc);
        $display("misuse flag test done");
        finish_test();
    end
endmodule
